// [dbg_trace_consts.vh]
`ifndef DBG_TRACE_CONSTS_VH
`define DBG_TRACE_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CTRL      8'h00
`define ADDR_TRIG      8'h04
`define ADDR_STATUS    8'h08
`define ADDR_FIFO      8'h0C
`define ADDR_IRQ_STAT  8'h10
`define ADDR_IRQ_MASK  8'h14

// ----------------------------------------
// debug_control_reg fields
// ----------------------------------------
`define CTL_ARM        0
`define CTL_DBG_EN     1
`define CTL_BRK_EN     2
`define CTL_TAG        3

// ----------------------------------------
// trigger_control_reg fields
// ----------------------------------------
`define TCTL_MODE_LSB  0
`define TCTL_MODE_MSB  3
`define TCTL_TAG_SEL   4
`define TCTL_BEGIN     5
`define TCTL_DQ_ONE    6
`define TCTL_DQ_TWO    7
`define TCTL_DV_ONE    8
`define TCTL_DV_TWO    9
`define TCTL_RESET     10'h020

// ----------------------------------------
// debug_status_reg fields
// ----------------------------------------
`define ST_ARMED       0
`define ST_M_ONE       1
`define ST_M_TWO       2
`define ST_FILL_LSB    8

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_DONE       0
`define IRQ_TRIG       1

// ----------------------------------------
// Trigger modes
// ----------------------------------------
`define MODE_ONE       4'h0
`define MODE_EITHER    4'h1
`define MODE_ONE_THEN  4'h2
`define MODE_EV_TWO    4'h3
`define MODE_EV_SEQ    4'h4
`define MODE_BOTH      4'h5
`define MODE_ONE_NOT   4'h6
`define MODE_EV_ONE    4'h7
`define MODE_TWO       4'h8

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// [debug_trigger_trace_control.v]
// Operation
// RULE1 - CPU finishes current instruction before force break
// RULE2 - CPU enters background mode on breakpoint
// RULE3 - Tag marks fetched opcode; execution enters background
// RULE4 - Tag select routes comparators through opcode tracking
// RULE5 - Separate opcode tracker for each comparator
// RULE6 - Four-bit field selects one of nine modes
// RULE7 - Begin stores after trigger; end stores circularly
// RULE8 - Arm write sets armed, clears flags, count
// RULE9 - Begin-trace run ends when FIFO full
// RULE10 - End-trace run ends on qualified trigger
// RULE11 - Writing zero to arm or enable stops
// RULE12 - Non-event modes store change-of-flow addresses
// RULE13 - Event-only modes store data in low byte
// RULE14 - Event-only modes ignore begin control, begin-type
// RULE15 - Optional direction qualification per comparator
// RULE16 - Break enable issues tag or force request
// RULE17 - Run end clears armed, keeps FIFO contents
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "dbg_trace_consts.vh"

module debug_trigger_trace_control #(
  parameter DEPTH = 8,
  parameter WIDTH = 16,
  parameter TRK_W = 2
) (
  input  wire             clock,
  input  wire             reset,
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  input  wire             cmp_one_hit,
  input  wire             cmp_two_hit,
  input  wire             bus_read,
  input  wire [7:0]       bus_data,
  input  wire             cof_valid,
  input  wire [WIDTH-1:0] cof_addr,
  input  wire [1:0]       tag_executed,
  input  wire             queue_flush,
  output wire [1:0]       queue_tag_mark,
  output wire             break_tag_req,
  output wire             break_force_req,
  output wire             irq
);

  localparam AW    = $clog2(DEPTH);
  localparam FILL_W = AW + 1;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [3:0]       ctrl_q;
  reg  [9:0]       trig_q;
  reg              armed_q;
  reg              m_one_q;
  reg              m_two_q;
  reg              started_q;
  reg              a_seen_q;
  reg  [1:0]       irq_stat_q;
  reg  [1:0]       irq_mask_q;
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_q;
  reg  [FILL_W-1:0] fill_q;

  wire [3:0] trigger_mode_field = trig_q[`TCTL_MODE_MSB:`TCTL_MODE_LSB];
  wire       tag_trigger_select = trig_q[`TCTL_TAG_SEL];
  wire       debug_enable_ctl   = ctrl_q[`CTL_DBG_EN];

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  wire wr_ctrl = wr_go & (s_axi_awaddr == `ADDR_CTRL) & s_axi_wstrb[0];
  wire wr_trig = wr_go & (s_axi_awaddr == `ADDR_TRIG);
  wire wr_ist  = wr_go & (s_axi_awaddr == `ADDR_IRQ_STAT) & s_axi_wstrb[0];
  wire wr_imsk = wr_go & (s_axi_awaddr == `ADDR_IRQ_MASK) & s_axi_wstrb[0];
  wire wr_map  = (s_axi_awaddr == `ADDR_CTRL) | (s_axi_awaddr == `ADDR_TRIG) |
                 (s_axi_awaddr == `ADDR_STATUS) | (s_axi_awaddr == `ADDR_FIFO) |
                 (s_axi_awaddr == `ADDR_IRQ_STAT) | (s_axi_awaddr == `ADDR_IRQ_MASK);

  wire arm_go  = wr_ctrl & s_axi_wdata[`CTL_ARM] & s_axi_wdata[`CTL_DBG_EN];  // [RULE8]
  wire sw_stop = wr_ctrl & ~(s_axi_wdata[`CTL_ARM] & s_axi_wdata[`CTL_DBG_EN]); // [RULE11]

  // ----------------------------------------
  // Comparator qualification
  // ----------------------------------------
  wire [1:0] hit;
  wire [1:0] qual;
  assign hit[0] = cmp_one_hit &
                  (~trig_q[`TCTL_DQ_ONE] | (bus_read == trig_q[`TCTL_DV_ONE])); // [RULE15]
  assign hit[1] = cmp_two_hit &
                  (~trig_q[`TCTL_DQ_TWO] | (bus_read == trig_q[`TCTL_DV_TWO])); // [RULE15]

  // ----------------------------------------
  // Opcode tracking, one per comparator
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : trk
      reg  [TRK_W-1:0] pend_q;
      wire             mark = tag_trigger_select & hit[g];
      wire             done = tag_trigger_select & tag_executed[g] & (pend_q != {TRK_W{1'b0}});
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          pend_q <= {TRK_W{1'b0}};
        end else if (queue_flush | ~tag_trigger_select) begin
          pend_q <= {TRK_W{1'b0}};
        end else if (mark & ~done & (pend_q != {TRK_W{1'b1}})) begin
          pend_q <= pend_q + {{(TRK_W-1){1'b0}}, 1'b1}; // [RULE5]
        end else if (done & ~mark) begin
          pend_q <= pend_q - {{(TRK_W-1){1'b0}}, 1'b1};
        end
      end
      assign queue_tag_mark[g] = mark;
      assign qual[g] = tag_trigger_select ? done : hit[g]; // [RULE4]
    end
  endgenerate

  // ----------------------------------------
  // Trigger mode decode
  // ----------------------------------------
  reg trig_now;
  reg ev_only;
  always @* begin
    trig_now = 1'b0;
    ev_only  = 1'b0;
    case (trigger_mode_field) // [RULE6]
      `MODE_ONE:      trig_now = qual[0];
      `MODE_EITHER:   trig_now = qual[0] | qual[1];
      `MODE_ONE_THEN: trig_now = a_seen_q & qual[1];
      `MODE_EV_TWO: begin
        trig_now = qual[1];
        ev_only  = 1'b1;
      end
      `MODE_EV_SEQ: begin
        trig_now = a_seen_q & qual[1];
        ev_only  = 1'b1;
      end
      `MODE_BOTH:     trig_now = qual[0] & qual[1];
      `MODE_ONE_NOT:  trig_now = qual[0] & ~qual[1];
      `MODE_EV_ONE: begin
        trig_now = qual[0];
        ev_only  = 1'b1;
      end
      `MODE_TWO:      trig_now = qual[1];
      default:        trig_now = 1'b0;
    endcase
  end

  wire run       = armed_q & debug_enable_ctl;
  wire end_trace = ~ev_only & ~trig_q[`TCTL_BEGIN]; // [RULE14]
  wire trig_run  = run & trig_now;

  // ----------------------------------------
  // Break requests
  // ----------------------------------------
  wire brk = debug_enable_ctl & ctrl_q[`CTL_BRK_EN] & (hit[0] | hit[1]);
  assign break_tag_req   = brk & ctrl_q[`CTL_TAG];  // [RULE16] [RULE3]
  assign break_force_req = brk & ~ctrl_q[`CTL_TAG]; // [RULE16] [RULE1] [RULE2]

  // ----------------------------------------
  // Trace FIFO store and run end
  // ----------------------------------------
  wire store = run & (ev_only ? trig_now :
               (cof_valid & (end_trace | started_q | trig_now))); // [RULE7]
  wire [WIDTH-1:0] store_data = ev_only ? {{(WIDTH-8){1'b0}}, bus_data} // [RULE13]
                                        : cof_addr;                     // [RULE12]
  wire full_next = store & (fill_q == DEPTH - 1);
  wire run_end   = run & ((~end_trace & full_next) |  // [RULE9]
                          (end_trace & trig_now));    // [RULE10]

  wire [AW-1:0] oldest = wr_ptr_q - fill_q[AW-1:0];
  wire          rd_fifo = rd_go & (s_axi_araddr == `ADDR_FIFO);
  wire          pop     = rd_fifo & ~armed_q & (fill_q != {FILL_W{1'b0}});

  always @(posedge clock) begin
    if (store) begin
      mem[wr_ptr_q] <= store_data;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= {AW{1'b0}};
      fill_q   <= {FILL_W{1'b0}};
    end else if (arm_go) begin
      wr_ptr_q <= {AW{1'b0}};
      fill_q   <= {FILL_W{1'b0}}; // [RULE8]
    end else if (store) begin
      wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (fill_q != DEPTH) begin
        fill_q <= fill_q + {{(FILL_W-1){1'b0}}, 1'b1};
      end
    end else if (pop) begin
      fill_q <= fill_q - {{(FILL_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Run state and match flags
  // ----------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      armed_q   <= 1'b0;
      m_one_q   <= 1'b0;
      m_two_q   <= 1'b0;
      started_q <= 1'b0;
      a_seen_q  <= 1'b0;
    end else if (arm_go) begin
      armed_q   <= 1'b1; // [RULE8]
      m_one_q   <= 1'b0;
      m_two_q   <= 1'b0;
      started_q <= 1'b0;
      a_seen_q  <= 1'b0;
    end else begin
      if (sw_stop | run_end | ~debug_enable_ctl) begin
        armed_q <= 1'b0; // [RULE11] [RULE17]
      end
      if (run & qual[0]) begin
        m_one_q  <= 1'b1;
        a_seen_q <= 1'b1;
      end
      if (run & qual[1]) begin
        m_two_q <= 1'b1;
      end
      if (trig_run) begin
        started_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Software registers and interrupts
  // ----------------------------------------
  wire [1:0] irq_set = {trig_run, run_end};
  assign irq = |(irq_stat_q & irq_mask_q);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q     <= 4'h0;
      trig_q     <= `TCTL_RESET;
      irq_stat_q <= 2'b00;
      irq_mask_q <= 2'b00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= s_axi_wdata[3:0];
      end
      if (wr_trig & s_axi_wstrb[0]) begin
        trig_q[7:0] <= s_axi_wdata[7:0];
      end
      if (wr_trig & s_axi_wstrb[1]) begin
        trig_q[9:8] <= s_axi_wdata[9:8];
      end
      if (wr_imsk) begin
        irq_mask_q <= s_axi_wdata[1:0];
      end
      irq_stat_q <= (irq_stat_q & ~(wr_ist ? s_axi_wdata[1:0] : 2'b00)) | irq_set;
    end
  end

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  reg [31:0] rd_val;
  reg        rd_ok;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `ADDR_CTRL:     rd_val = {28'h000_0000, ctrl_q[3:1], armed_q};
      `ADDR_TRIG:     rd_val = {22'h00_0000, trig_q};
      `ADDR_STATUS: begin
        rd_val[`ST_ARMED] = armed_q;
        rd_val[`ST_M_ONE] = m_one_q;
        rd_val[`ST_M_TWO] = m_two_q;
        rd_val[`ST_FILL_LSB +: FILL_W] = fill_q;
      end
      `ADDR_FIFO:     rd_val[WIDTH-1:0] = mem[oldest];
      `ADDR_IRQ_STAT: rd_val[1:0] = irq_stat_q;
      `ADDR_IRQ_MASK: rd_val[1:0] = irq_mask_q;
      default:        rd_ok = 1'b0;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rdata  <= (rd_fifo & (armed_q | (fill_q == {FILL_W{1'b0}}))) ?
                        32'h0000_0000 : rd_val;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // debug_trigger_trace_control

// [dbg_props.sv]
`timescale 1ns/1ps
`include "dbg_trace_consts.vh"
module dbg_props (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        cmp_one_hit,
  input wire logic        cmp_two_hit,
  input wire logic [1:0]  queue_tag_mark,
  input wire logic        break_tag_req,
  input wire logic        break_force_req
);
  // ----------------------------------------
  // Bus and request checks
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence wr_take; s_axi_awvalid && s_axi_awready; endsequence
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  write_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  unmapped_read_a: assert property (rd_take ##0 (s_axi_araddr > `ADDR_IRQ_MASK)
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answered");
  break_cause_a: assert property (break_tag_req || break_force_req |-> cmp_one_hit || cmp_two_hit)
    else $error("break without hit");
  break_kind_a: assert property (!(break_tag_req && break_force_req))
    else $error("break both kinds");
  mark_cause_a: assert property ((queue_tag_mark & ~{cmp_two_hit, cmp_one_hit}) == 2'b00)
    else $error("tag mark without hit");
endmodule // dbg_props
bind debug_trigger_trace_control dbg_props i_props (
  .clock, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .cmp_one_hit, .cmp_two_hit, .queue_tag_mark, .break_tag_req, .break_force_req
);

// [cpu_queue_model.sv]
`timescale 1ns/1ps
module cpu_queue_model #(
  parameter int LAT = 4
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [1:0] queue_tag_mark,
  input  wire logic       queue_flush,
  input  wire logic       break_force_req,
  output logic [1:0]      tag_executed,
  output logic            in_background
);
  // ----------------------------------------
  // Tagged opcodes retire LAT cycles on
  // ----------------------------------------
  logic [LAT-1:0] pipe_one_q;
  logic [LAT-1:0] pipe_two_q;
  logic           force_q;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pipe_one_q    <= '0;
      pipe_two_q    <= '0;
      force_q       <= 1'b0;
      in_background <= 1'b0;
    end else if (queue_flush) begin
      pipe_one_q <= '0;
      pipe_two_q <= '0;
    end else begin
      pipe_one_q <= {pipe_one_q[LAT-2:0], queue_tag_mark[0]};
      pipe_two_q <= {pipe_two_q[LAT-2:0], queue_tag_mark[1]};
      force_q    <= break_force_req;
      if (force_q || |tag_executed) in_background <= 1'b1;
    end
  end
  assign tag_executed = {pipe_two_q[LAT-1], pipe_one_q[LAT-1]};
endmodule // cpu_queue_model

// [tb_debug_trigger_trace_control.sv]
`timescale 1ns/1ps
`include "dbg_trace_consts.vh"
module tb_debug_trigger_trace_control;
  logic        clock, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, cmp_one_hit, cmp_two_hit, bus_read, cof_valid, queue_flush;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        break_tag_req, break_force_req, irq, halted;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, bus_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [15:0] cof_addr;
  logic [1:0]  tag_executed, queue_tag_mark, s_axi_bresp, s_axi_rresp, last_resp, brk_seen, mark_seen;
  int          miscompares = 0, tests_run = 0, m;
  localparam logic [15:0] FIRST_HIT  = 16'h00C3;
  localparam logic [15:0] SECOND_HIT = 16'h01DF;
  debug_trigger_trace_control i_dut (
    .clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmp_one_hit, .cmp_two_hit, .bus_read, .bus_data, .cof_valid, .cof_addr, .tag_executed,
    .queue_flush, .queue_tag_mark, .break_tag_req, .break_force_req, .irq);
  cpu_queue_model i_cpu (.clock, .reset, .queue_tag_mark, .queue_flush, .break_force_req,
    .tag_executed, .in_background(halted));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ----------------------------------------
  // Bus, stimulus and compare tasks
  // ----------------------------------------
  task tally_and_finish();
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
    do @(posedge clock); while (!s_axi_awready);
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge clock);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task rc(input string n, input logic [7:0] a, input logic [31:0] e);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge clock);
    {rv, last_resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge clock);
    chk(n, rv, e);
  endtask
  task ev(input logic [2:0] h, input logic c, input logic [15:0] a);
    {queue_flush, cmp_two_hit, cmp_one_hit, cof_valid, cof_addr, bus_data} <= {h, c, a, a[7:0]};
    @(posedge clock);
    {brk_seen, mark_seen} = {break_tag_req, break_force_req, queue_tag_mark};
    {queue_flush, cmp_two_hit, cmp_one_hit, cof_valid} <= 4'h0;
    @(posedge clock);
  endtask
  initial begin
    #100_000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cmp_one_hit, cmp_two_hit, bus_read, cof_valid, queue_flush, cof_addr} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, bus_data} = '0;
    {s_axi_wstrb, reset} = {4'hF, 1'b1};
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rc("trig_reset", `ADDR_TRIG, 32'h0000_0020);
    rc("status_reset", `ADDR_STATUS, 32'h0000_0000);
    rc("unmapped_data", 8'h40, 32'h0000_0000);
    chk("unmapped_resp", last_resp, `RESP_SLVERR);
    wr(8'h40, 32'h0000_0000);
    chk("unmapped_wresp", last_resp, `RESP_SLVERR);
    for (m = 0; m < 9; m++) begin
      wr(`ADDR_TRIG, 32'h0000_0020 | m);
      wr(`ADDR_IRQ_STAT, 32'h0000_0003);
      wr(`ADDR_CTRL, 32'h0000_0003);
      ev(3'b001, 1'b0, 16'h0000);
      rc("mode_first", `ADDR_IRQ_STAT, {30'h0, FIRST_HIT[m], 1'b0});
      ev(3'b010, 1'b0, 16'h0000);
      rc("mode_second", `ADDR_IRQ_STAT, {30'h0, SECOND_HIT[m], 1'b0});
    end
    wr(`ADDR_TRIG, 32'h0000_0020);
    wr(`ADDR_CTRL, 32'h0000_0003);
    ev(3'b000, 1'b1, 16'h1111);
    for (m = 0; m < 8; m++) ev({2'b00, m == 0}, 1'b1, 16'h2000 + m[15:0]);
    rc("begin_done", `ADDR_STATUS, 32'h0000_0802);
    for (m = 0; m < 8; m++) rc("begin_fifo", `ADDR_FIFO, 32'h0000_2000 + m);
    wr(`ADDR_TRIG, 32'h0000_0000);
    wr(`ADDR_CTRL, 32'h0000_0003);
    rc("arm_clears", `ADDR_STATUS, 32'h0000_0001);
    for (m = 0; m < 11; m++) ev({2'b00, m == 10}, 1'b1, 16'h3000 + m[15:0]);
    rc("end_done", `ADDR_STATUS, 32'h0000_0802);
    for (m = 3; m < 11; m++) rc("end_fifo", `ADDR_FIFO, 32'h0000_3000 + m);
    wr(`ADDR_TRIG, 32'h0000_0007);
    wr(`ADDR_CTRL, 32'h0000_0003);
    for (m = 0; m < 8; m++) ev(3'b001, 1'b1, 16'hFFA0 + m[15:0]);
    rc("event_done", `ADDR_STATUS, 32'h0000_0802);
    for (m = 0; m < 8; m++) rc("event_fifo", `ADDR_FIFO, 32'h0000_00A0 + m);
    for (m = 1; m < 3; m++) begin
      wr(`ADDR_CTRL, 32'h0000_0003);
      wr(`ADDR_CTRL, m);
      rc("stop_run", `ADDR_STATUS, 32'h0000_0000);
    end
    wr(`ADDR_TRIG, 32'h0000_0160);
    wr(`ADDR_CTRL, 32'h0000_0007);
    ev(3'b001, 1'b0, 16'h0000);
    chk("wrong_dir_brk", brk_seen, 32'h0000_0000);
    chk("cpu_idle", halted, 32'h0000_0000);
    bus_read <= 1'b1;
    ev(3'b001, 1'b0, 16'h0000);
    chk("force_brk", brk_seen, 32'h0000_0001);
    rc("dir_flag", `ADDR_STATUS, 32'h0000_0003);
    chk("cpu_halted", halted, 32'h0000_0001);
    wr(`ADDR_CTRL, 32'h0000_000F);
    ev(3'b001, 1'b0, 16'h0000);
    chk("tag_brk", brk_seen, 32'h0000_0002);
    chk("no_mark", mark_seen, 32'h0000_0000);
    wr(`ADDR_TRIG, 32'h0000_0031);
    wr(`ADDR_IRQ_STAT, 32'h0000_0003);
    wr(`ADDR_CTRL, 32'h0000_0003);
    ev(3'b001, 1'b0, 16'h0000);
    ev(3'b100, 1'b0, 16'h0000);
    // Let any tagged opcode retire
    repeat (8) @(posedge clock);
    rc("flushed_tag", `ADDR_IRQ_STAT, 32'h0000_0000);
    ev(3'b011, 1'b0, 16'h0000);
    chk("both_marks", mark_seen, 32'h0000_0003);
    repeat (8) @(posedge clock);
    rc("tag_trigger", `ADDR_IRQ_STAT, 32'h0000_0002);
    chk("irq_masked", irq, 32'h0000_0000);
    wr(`ADDR_IRQ_MASK, 32'h0000_0002);
    chk("irq_up", irq, 32'h0000_0001);
    wr(`ADDR_IRQ_STAT, 32'h0000_0002);
    chk("irq_down", irq, 32'h0000_0000);
    chk("mapped_wresp", last_resp, `RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    wr(`ADDR_TRIG, 32'h0000_03FF);
    s_axi_wstrb <= 4'hF;
    rc("strobe_lane", `ADDR_TRIG, 32'h0000_00FF);
    tally_and_finish();
  end
endmodule // tb_debug_trigger_trace_control
